//--- common/ans_pkg.sv
// Contract
// RL1: Three-operand and-not: first AND NOT second.
// RL2: Three-operand mode bits pick register or indirect.
// RL3: Flags change only for extended-precision destinations.
// RL4: And-not: clear underflow, overflow; set sign, zero.
// RL5: Saturation mode bit never alters behaviour.
// RL6: Count is seven-bit two's complement value.
// RL7: Positive count: left, zero fill, carry out.
// RL8: Negative count: right, sign fill, carry out.
// RL9: Zero count: no shift, carry cleared.
// RL10: Shift count and operands are signed.
// RL11: Overflow sets overflow and latched overflow.
// RL12: Shift flags: last carry, underflow cleared, sign, zero.
// RL13: Two-operand mode: register, direct, indirect, immediate.
// RL14: Each operation completes in one execute cycle.
// RL15: Left overflow when lost or sign bits differ.
package ans_pkg;
   // ***************************************************
   // Register map, byte offsets
   // ***************************************************
   localparam logic [7:0] OFS_CTRL     = 8'h00; // Operation launch
   localparam logic [7:0] OFS_IMM      = 8'h04; // Immediate operand
   localparam logic [7:0] OFS_FLAGS    = 8'h08; // Condition flags
   localparam logic [7:0] OFS_RESULT   = 8'h0c; // Last result, RO
   localparam logic [7:0] OFS_INT_STAT = 8'h10; // Sticky events, RO
   localparam logic [7:0] OFS_INT_CLR  = 8'h14; // Event clear, WO
   localparam logic [7:0] OFS_INT_EN   = 8'h18; // Event enable
   localparam logic [7:0] OFS_REG0     = 8'h20; // Register file base
   localparam logic [7:0] OFS_MEM0     = 8'h40; // Operand memory base
   // ***************************************************
   // Control word fields
   // ***************************************************
   localparam int CTRL_OP_LSB   = 0;  // Operation select
   localparam int CTRL_MODE_LSB = 2;  // Operand mode field
   localparam int CTRL_DST_LSB  = 4;  // Destination index
   localparam int CTRL_S1_LSB   = 9;  // First source index
   localparam int CTRL_S2_LSB   = 14; // Second source or count index
   localparam int CTRL_GO_BIT   = 31; // Launch, self clearing
   localparam int IDX_W         = 5;  // Register index width
   localparam int CNT_W         = 7;  // Shift count width
   localparam int NUM_XREGS     = 8;  // Extended-precision registers
   localparam int MEM_WORDS     = 16; // Operand memory depth
   // ***************************************************
   // Flag and event bit positions
   // ***************************************************
   localparam int FL_CARRY       = 0; // Carry
   localparam int FL_OVF         = 1; // Overflow
   localparam int FL_ZERO        = 2; // Zero result
   localparam int FL_NEG         = 3; // Negative result
   localparam int FL_UNDERFLOW   = 4; // Underflow
   localparam int FL_LATCHED_OVF = 5; // Latched overflow
   localparam int FL_LATCHED_UNF = 6; // Latched underflow
   localparam int FL_SAT_MODE    = 7; // Saturation mode bit
   localparam int EV_DONE        = 0; // Operation finished
   localparam int EV_OVF         = 1; // Shift overflowed
   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;
   localparam logic [7:0]  RST_FLAGS = 8'h00;
   localparam logic [1:0]  RST_EV    = 2'h0;
   // Operation codes carried in the control word
   typedef enum logic [1:0] {
      OP_ANDC_TWO,
      OP_ANDC_THREE,
      OP_SHIFT_TWO,
      OP_SHIFT_THREE
   } ans_op_t;
endpackage : ans_pkg

//--- common/ans_exec_if.sv
// ***************************************************
// Operands and results between core and datapaths
// ***************************************************
interface ans_exec_if;
   logic [31:0] opnd_a;   // Shifted value or first source
   logic [31:0] opnd_b;   // Complemented source or count word
   logic [6:0]  count;    // Seven-bit shift count
   logic [31:0] and_res;  // And-not result
   logic [31:0] sh_res;   // Shift result
   logic        sh_carry; // Last bit shifted out
   logic        sh_ovf;   // Shift overflow
   modport core  (output opnd_a, opnd_b, count,
                  input  and_res, sh_res, sh_carry, sh_ovf);
   modport lgc   (input  opnd_a, opnd_b, output and_res);
   modport shift (input  opnd_a, count,
                  output sh_res, sh_carry, sh_ovf);
endinterface : ans_exec_if

//--- rtl/ans_andc.sv
// ***************************************************
// Bitwise and with complement
// ***************************************************
module ans_andc (
   ans_exec_if.lgc x
);
   // Unsigned, no carry or overflow involved
   always_comb begin
      x.and_res = x.opnd_a & ~x.opnd_b; // see RL1
   end
endmodule : ans_andc

//--- rtl/ans_shifter.sv
// ***************************************************
// Arithmetic shift by signed seven-bit count
// ***************************************************
module ans_shifter (
   ans_exec_if.shift x
);
   logic [6:0]         mag;   // Count magnitude, up to 64
   logic [95:0]        lwide; // Left shift with lost bits
   logic [31:0]        lres;  // Left shift result
   logic signed [32:0] rwide; // Right shift with carry slot
   logic signed [63:0] back;  // Left result shifted back

   // Direction from count sign, carry from last bit out
   always_comb begin
      mag   = x.count[6] ? 7'(-x.count) : x.count; // see RL6
      lwide = {64'h0, x.opnd_a} << mag;            // see RL7
      lres  = lwide[31:0];
      rwide = $signed({x.opnd_a, 1'b0}) >>> mag;   // see RL8
      back  = $signed({{32{lres[31]}}, lres}) >>> mag;
      if (x.count == 7'h00) begin
         // No shift, carry cleared
         x.sh_res   = x.opnd_a;                    // see RL9
         x.sh_carry = 1'b0;
         x.sh_ovf   = 1'b0;
      end else if (!x.count[6]) begin
         // Left: overflow when shifting back differs
         x.sh_res   = lres;
         x.sh_carry = lwide[32];
         x.sh_ovf   = back != {{32{x.opnd_a[31]}}, x.opnd_a}; // see RL15
      end else begin
         // Right: sign extended, never overflows
         x.sh_res   = rwide[32:1];                 // see RL10
         x.sh_carry = rwide[0];
         x.sh_ovf   = 1'b0;
      end
   end
endmodule : ans_shifter

//--- rtl/ans_unit.sv
// ***************************************************
// And-not and arithmetic shift unit, AHB-Lite slave
// ***************************************************
module ans_unit (
   input  wire logic        i_clk_sys,   // Core clock
   input  wire logic        i_sys_rst,   // Sync reset, high
   input  wire logic        i_ce,        // Clock enable
   input  wire logic        i_hsel,      // Slave select
   input  wire logic [31:0] i_haddr,     // Byte address
   input  wire logic [1:0]  i_htrans,    // Transfer type
   input  wire logic        i_hwrite,    // Write when high
   input  wire logic [2:0]  i_hsize,     // Word only
   input  wire logic [31:0] i_hwdata,    // Write data
   input  wire logic        i_hready,    // Bus ready
   output logic      [31:0] o_hrdata,    // Read data
   output logic             o_hreadyout, // Slave ready
   output logic             o_hresp,     // Always OKAY
   output logic             o_irq        // Level interrupt
);
   // ***************************************************
   // State
   // ***************************************************
   logic [31:0] regs_q [ans_pkg::NUM_XREGS]; // Registers R0..R7
   logic [31:0] regs_d [ans_pkg::NUM_XREGS];
   logic [31:0] mem_q  [ans_pkg::MEM_WORDS]; // Operand memory
   logic [31:0] mem_d  [ans_pkg::MEM_WORDS];
   logic [31:0] ctrl_q,   ctrl_d;   // Last control word
   logic [31:0] imm_q,    imm_d;    // Immediate operand
   logic [31:0] result_q, result_d; // Last result
   logic [7:0]  flags_q,  flags_d;  // Condition flags
   logic [1:0]  ist_q,    ist_d;    // Sticky events
   logic [1:0]  ien_q,    ien_d;    // Event enables
   logic        irq_q,    irq_d;    // Interrupt level
   logic        wr_q,     wr_d;     // Write data phase
   logic        rd_q,     rd_d;     // Read wait cycle
   logic [7:0]  addr_q,   addr_d;   // Captured address
   logic [31:0] hrd_q,    hrd_d;    // Read data
   logic        hrdy_q,   hrdy_d;   // Ready out
   logic        hresp_q;            // Response, OKAY
   // ***************************************************
   // Decode and datapath wiring
   // ***************************************************
   ans_exec_if       ex ();         // Datapath carrier
   ans_pkg::ans_op_t c_op;          // Launched operation
   logic [1:0]       c_mode;        // Operand mode field
   logic [4:0]       c_dst;         // Destination index
   logic [4:0]       c_s1;          // First source index
   logic [4:0]       c_s2;          // Second source index
   logic             accept;        // Address phase taken
   logic             wr_en;         // Bus write this cycle
   logic             go;            // Execute cycle
   logic             is_shift;      // Shift operation
   logic             three;         // Three-operand form
   logic             dst_lo;        // Destination R0..R7
   logic [31:0]      res;           // Selected result
   logic [1:0]       ev;            // Events this cycle

   ans_andc u_andc (
      .x (ex)
   );

   ans_shifter u_shifter (
      .x (ex)
   );

   // Word-aligned offset match
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] ofs);
      return a[7:2] == ofs[7:2];
   endfunction : hit

   // Register operand, indices above R7 read zero
   function automatic logic [31:0] reg_val(input logic [4:0] i);
      return (i < 5'(ans_pkg::NUM_XREGS)) ? regs_q[i[2:0]] : 32'h0;
   endfunction : reg_val

   // Indirect operand through a register
   function automatic logic [31:0] ind_val(input logic [4:0] i);
      logic [31:0] p;
      p = reg_val(i);
      return mem_q[p[3:0]];
   endfunction : ind_val

   // Two-operand general addressing
   function automatic logic [31:0] gen_val(input logic [1:0] m,
                                           input logic [4:0] i);
      logic [31:0] v;
      v = reg_val(i);
      unique case (m)
         2'b00: v = reg_val(i);     // Register
         2'b01: v = mem_q[i[3:0]];  // Direct
         2'b10: v = ind_val(i);     // Indirect
         2'b11: v = imm_q;          // Immediate, not extended
      endcase
      return v;
   endfunction : gen_val

   // Register read multiplexer
   function automatic logic [31:0] rd_mux(input logic [7:0] a);
      logic [31:0] v;
      v = ans_pkg::RST_WORD;
      if (hit(a, ans_pkg::OFS_CTRL)) v = ctrl_q;
      else if (hit(a, ans_pkg::OFS_IMM)) v = imm_q;
      else if (hit(a, ans_pkg::OFS_FLAGS)) v = {24'h0, flags_q};
      else if (hit(a, ans_pkg::OFS_RESULT)) v = result_q;
      else if (hit(a, ans_pkg::OFS_INT_STAT)) v = {30'h0, ist_q};
      else if (hit(a, ans_pkg::OFS_INT_EN)) v = {30'h0, ien_q};
      else if (a[7:5] == ans_pkg::OFS_REG0[7:5]) v = regs_q[a[4:2]];
      else if (a[7:6] == ans_pkg::OFS_MEM0[7:6]) v = mem_q[a[5:2]];
      return v;
   endfunction : rd_mux

   // ***************************************************
   // Launch decode and operand fetch
   // ***************************************************
   always_comb begin
      accept   = i_hsel & i_htrans[1] & i_hready;
      wr_en    = wr_q;
      c_op     = ans_pkg::ans_op_t'(i_hwdata[ans_pkg::CTRL_OP_LSB +: 2]);
      c_mode   = i_hwdata[ans_pkg::CTRL_MODE_LSB +: 2];
      c_dst    = i_hwdata[ans_pkg::CTRL_DST_LSB +: ans_pkg::IDX_W];
      c_s1     = i_hwdata[ans_pkg::CTRL_S1_LSB +: ans_pkg::IDX_W];
      c_s2     = i_hwdata[ans_pkg::CTRL_S2_LSB +: ans_pkg::IDX_W];
      // Execute cycle is the control write data phase
      go       = wr_en & hit(addr_q, ans_pkg::OFS_CTRL)
                 & i_hwdata[ans_pkg::CTRL_GO_BIT];          // see RL14
      is_shift = c_op inside {ans_pkg::OP_SHIFT_TWO,
                              ans_pkg::OP_SHIFT_THREE};
      three    = c_op inside {ans_pkg::OP_ANDC_THREE,
                              ans_pkg::OP_SHIFT_THREE};
      dst_lo   = c_dst < 5'(ans_pkg::NUM_XREGS);
      if (three) begin
         ex.opnd_a = c_mode[0] ? ind_val(c_s1) : reg_val(c_s1); // see RL2
         ex.opnd_b = c_mode[1] ? ind_val(c_s2) : reg_val(c_s2); // see RL2
      end else begin
         ex.opnd_a = reg_val(c_dst);
         ex.opnd_b = gen_val(c_mode, c_s2);                      // see RL13
      end
      ex.count = ex.opnd_b[ans_pkg::CNT_W-1:0];                  // see RL6
      res      = is_shift ? ex.sh_res : ex.and_res;
   end

   // ***************************************************
   // Architectural state next values
   // ***************************************************
   always_comb begin
      regs_d   = regs_q;
      mem_d    = mem_q;
      ctrl_d   = ctrl_q;
      imm_d    = imm_q;
      result_d = result_q;
      flags_d  = flags_q;
      ien_d    = ien_q;
      ist_d    = ist_q;
      ev       = 2'b00;
      // Bus writes, unmapped offsets ignored
      if (wr_en) begin
         if (hit(addr_q, ans_pkg::OFS_CTRL)) begin
            ctrl_d = i_hwdata;
            ctrl_d[ans_pkg::CTRL_GO_BIT] = 1'b0;
         end else if (hit(addr_q, ans_pkg::OFS_IMM)) begin
            imm_d = i_hwdata;
         end else if (hit(addr_q, ans_pkg::OFS_FLAGS)) begin
            flags_d = i_hwdata[7:0];
         end else if (hit(addr_q, ans_pkg::OFS_INT_CLR)) begin
            ist_d = ist_q & ~i_hwdata[1:0];
         end else if (hit(addr_q, ans_pkg::OFS_INT_EN)) begin
            ien_d = i_hwdata[1:0];
         end else if (addr_q[7:5] == ans_pkg::OFS_REG0[7:5]) begin
            regs_d[addr_q[4:2]] = i_hwdata;
         end else if (addr_q[7:6] == ans_pkg::OFS_MEM0[7:6]) begin
            mem_d[addr_q[5:2]] = i_hwdata;
         end
      end
      // Single-cycle execute, saturation bit never read
      if (go) begin                                          // see RL5
         result_d            = res;                          // see RL14
         ev[ans_pkg::EV_DONE] = 1'b1;
         ev[ans_pkg::EV_OVF]  = is_shift & ex.sh_ovf;
         if (dst_lo) begin                                   // see RL3
            regs_d[c_dst[2:0]] = res;
            flags_d[ans_pkg::FL_UNDERFLOW] = 1'b0;
            flags_d[ans_pkg::FL_NEG]       = res[31];
            flags_d[ans_pkg::FL_ZERO]      = res == 32'h0;
            if (is_shift) begin
               flags_d[ans_pkg::FL_CARRY] = ex.sh_carry;     // see RL12
               flags_d[ans_pkg::FL_OVF]   = ex.sh_ovf;       // see RL11
               if (ex.sh_ovf) begin
                  flags_d[ans_pkg::FL_LATCHED_OVF] = 1'b1;   // see RL11
               end
            end else begin
               flags_d[ans_pkg::FL_OVF] = 1'b0;              // see RL4
            end
         end
      end
      // Set wins over a clear in the same cycle
      ist_d = ist_d | ev;
      irq_d = |(ist_d & ien_d);
   end

   // ***************************************************
   // Bus phase tracking, one wait state on reads
   // ***************************************************
   always_comb begin
      wr_d   = accept & i_hwrite;
      rd_d   = accept & ~i_hwrite;
      addr_d = accept ? i_haddr[7:0] : addr_q;
      hrdy_d = ~(accept & ~i_hwrite);
      hrd_d  = rd_q ? rd_mux(addr_q) : hrd_q;
   end

   // Register every group, frozen while enable is low
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         regs_q   <= '{default: ans_pkg::RST_WORD};
         mem_q    <= '{default: ans_pkg::RST_WORD};
         ctrl_q   <= ans_pkg::RST_WORD;
         imm_q    <= ans_pkg::RST_WORD;
         result_q <= ans_pkg::RST_WORD;
         flags_q  <= ans_pkg::RST_FLAGS;
         ist_q    <= ans_pkg::RST_EV;
         ien_q    <= ans_pkg::RST_EV;
         irq_q    <= 1'b0;
         wr_q     <= 1'b0;
         rd_q     <= 1'b0;
         addr_q   <= 8'h00;
         hrd_q    <= ans_pkg::RST_WORD;
         hrdy_q   <= 1'b1;
         hresp_q  <= 1'b0;
      end else if (i_ce) begin
         regs_q   <= regs_d;
         mem_q    <= mem_d;
         ctrl_q   <= ctrl_d;
         imm_q    <= imm_d;
         result_q <= result_d;
         flags_q  <= flags_d;
         ist_q    <= ist_d;
         ien_q    <= ien_d;
         irq_q    <= irq_d;
         wr_q     <= wr_d;
         rd_q     <= rd_d;
         addr_q   <= addr_d;
         hrd_q    <= hrd_d;
         hrdy_q   <= hrdy_d;
         hresp_q  <= 1'b0;
      end
   end

   assign o_hrdata    = hrd_q;
   assign o_hreadyout = hrdy_q;
   assign o_hresp     = hresp_q;
   assign o_irq       = irq_q;

   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   sequence s_go_andc;
      go && i_ce && !is_shift && dst_lo;
   endsequence
   sequence s_go_shift;
      go && i_ce && is_shift && dst_lo;
   endsequence

   property p_andc3_result;
      go && i_ce && c_op == ans_pkg::OP_ANDC_THREE |=>
         result_q == ($past(ex.opnd_a) & ~$past(ex.opnd_b));
   endproperty
   a_andc3_result: assert property (p_andc3_result) // see RL1
      else $error("and-not result wrong");

   property p_src_select;
      go && three && c_mode == 2'b01 |->
         ex.opnd_a == mem_q[(c_s1 < 5'h08) ? regs_q[c_s1[2:0]][3:0] : 4'h0]
         && ex.opnd_b == ((c_s2 < 5'h08) ? regs_q[c_s2[2:0]] : 32'h0);
   endproperty
   a_src_select: assert property (p_src_select) // see RL2
      else $error("operand mode select wrong");

   property p_flags_hold;
      go && i_ce && !dst_lo |=> $stable(flags_q);
   endproperty
   a_flags_hold: assert property (p_flags_hold) // see RL3
      else $error("flags changed for high destination");

   property p_andc_flags;
      s_go_andc |=> !flags_q[ans_pkg::FL_UNDERFLOW]
         && !flags_q[ans_pkg::FL_OVF]
         && flags_q[ans_pkg::FL_NEG] == result_q[31]
         && flags_q[ans_pkg::FL_ZERO] == (result_q == 32'h0)
         && $stable(flags_q[ans_pkg::FL_CARRY])
         && $stable(flags_q[ans_pkg::FL_LATCHED_OVF]);
   endproperty
   a_andc_flags: assert property (p_andc_flags) // see RL4
      else $error("and-not flags wrong");

   property p_sat_ignored;
      go && i_ce |=> $stable(flags_q[ans_pkg::FL_SAT_MODE]);
   endproperty
   a_sat_ignored: assert property (p_sat_ignored) // see RL5
      else $error("saturation bit disturbed");

   property p_count_range;
      go && i_ce && is_shift && ex.count == 7'h60 |=>
         result_q == {32{$past(ex.opnd_a[31])}};
   endproperty
   a_count_range: assert property (p_count_range) // see RL6
      else $error("shift by minus 32 wrong");

   property p_left_one;
      go && i_ce && is_shift && ex.count == 7'h01 |->
         ex.sh_res == {ex.opnd_a[30:0], 1'b0}
         && ex.sh_carry == ex.opnd_a[31];
   endproperty
   a_left_one: assert property (p_left_one) // see RL7
      else $error("left shift by one wrong");

   property p_right_one;
      s_go_shift ##0 ex.count == 7'h7f |=>
         result_q == {$past(ex.opnd_a[31]), $past(ex.opnd_a[31:1])}
         && flags_q[ans_pkg::FL_CARRY] == $past(ex.opnd_a[0]);
   endproperty
   a_right_one: assert property (p_right_one) // see RL8
      else $error("right shift by one wrong");

   property p_count_zero;
      s_go_shift ##0 ex.count == 7'h00 |=>
         result_q == $past(ex.opnd_a) && !flags_q[ans_pkg::FL_CARRY];
   endproperty
   a_count_zero: assert property (p_count_zero) // see RL9
      else $error("zero count wrong");

   property p_shift_ovf;
      s_go_shift ##0 ex.sh_ovf |=> flags_q[ans_pkg::FL_OVF]
         && flags_q[ans_pkg::FL_LATCHED_OVF] && ist_q[ans_pkg::EV_OVF];
   endproperty
   a_shift_ovf: assert property (p_shift_ovf) // see RL11
      else $error("overflow not flagged");

   property p_shift_flags;
      s_go_shift |=> !flags_q[ans_pkg::FL_UNDERFLOW]
         && flags_q[ans_pkg::FL_NEG] == result_q[31]
         && $stable(flags_q[ans_pkg::FL_LATCHED_UNF]);
   endproperty
   a_shift_flags: assert property (p_shift_flags) // see RL12
      else $error("shift flags wrong");

   property p_one_cycle;
      go && i_ce && dst_lo |=> regs_q[$past(c_dst[2:0])] == result_q
         && ist_q[ans_pkg::EV_DONE];
   endproperty
   a_one_cycle: assert property (p_one_cycle) // see RL14
      else $error("result not written in one cycle");

   property p_left_ovf;
      go && is_shift && ex.count == 7'h01 |->
         ex.sh_ovf == (ex.opnd_a[31] ^ ex.opnd_a[30]);
   endproperty
   a_left_ovf: assert property (p_left_ovf) // see RL15
      else $error("left overflow detection wrong");

   property p_irq_level;
      o_irq == |(ist_q & ien_q);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt level wrong");
endmodule : ans_unit

//--- tb/ans_unit_tb.sv
module ans_unit_tb;
   timeunit 1ns;
   timeprecision 100ps;
   // ***************************************************
   // Clock, bus signals and counters
   // ***************************************************
   logic        clk = 1'b0;           // Core clock, 40 MHz
   logic        rst = 1'b1;           // Sync reset, high
   logic        ce = 1'b1;            // Clock enable
   logic        hsel = 1'b0;          // Slave select
   logic [31:0] haddr = 32'h0;        // Byte address
   logic [1:0]  htrans = 2'h0;        // Transfer type
   logic        hwrite = 1'b0;        // Write when high
   logic [31:0] hwdata = 32'h0;       // Write data
   logic [31:0] hrdata;               // Read data
   logic        hready;               // Slave ready, fed back
   logic        hresp;                // Response
   logic        irq;                  // Level interrupt
   int          fail_count = 0;       // Mismatches
   int          total_checks = 0;     // Comparisons
   always #12.5 clk = ~clk;
   ans_unit u_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_ce(ce),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
      .o_hresp(hresp), .o_irq(irq));
   // Verdict and end of run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         $display("FAIL %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask : chk
   // One AHB-Lite single word transfer, entered just after an edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 99);
      r = hrdata;
      if (n >= 99) begin
         fail_count++;
         stop_test();
      end
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr
   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(nm, e, r);
   endtask : rdc
   function automatic logic [7:0] ra(input int i);
      return ans_pkg::OFS_REG0 + 8'(4 * i);
   endfunction : ra
   // Launch one operation through the control word
   task automatic go(input logic [1:0] op, input logic [1:0] md,
                     input int d, input int s1, input int s2);
      wr(ans_pkg::OFS_CTRL, (32'h1 << ans_pkg::CTRL_GO_BIT)
         | (32'(s2) << ans_pkg::CTRL_S2_LSB)
         | (32'(s1) << ans_pkg::CTRL_S1_LSB)
         | (32'(d) << ans_pkg::CTRL_DST_LSB)
         | (32'(md) << ans_pkg::CTRL_MODE_LSB)
         | (32'(op) << ans_pkg::CTRL_OP_LSB));
   endtask : go
   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_andc();
      wr(ra(3), 32'h0000_0c2f);
      wr(ra(5), 32'h0000_0a02);
      wr(ans_pkg::OFS_FLAGS, 32'h0000_00a3);
      go(2'h1, 2'h0, 7, 3, 5);
      rdc("andc3 reg", ra(7), 32'h0000_042d);
      rdc("andc flags", ans_pkg::OFS_FLAGS, 32'h0000_00a1);
      wr(ra(1), 32'h0000_00cf);
      wr(ra(2), 32'h0000_0003);
      wr(ans_pkg::OFS_MEM0 + 8'h0c, 32'h0000_0fff);
      go(2'h1, 2'h1, 0, 2, 1);
      rdc("andc3 indirect", ra(0), 32'h0000_0f30);
      wr(ans_pkg::OFS_IMM, 32'hffff_ffff);
      go(2'h0, 2'h3, 7, 0, 0);
      rdc("andc2 imm", ra(7), 32'h0);
      rdc("andc2 zero", ans_pkg::OFS_FLAGS, 32'h0000_00a5);
      $display("test and-not done");
   endtask : t_andc
   task automatic t_shift();
      wr(ans_pkg::OFS_FLAGS, 32'h0);
      wr(ra(3), 32'h000a_e000);
      wr(ra(1), 32'h0000_0010);
      go(2'h2, 2'h0, 3, 0, 1);
      rdc("shl res", ra(3), 32'he000_0000);
      rdc("shl flags", ans_pkg::OFS_FLAGS, 32'h0000_002a);
      wr(ra(5), 32'haec0_0001);
      wr(ra(4), 32'h0000_0002);
      wr(ans_pkg::OFS_MEM0 + 8'h08, 32'h0000_ffe8);
      go(2'h3, 2'h2, 6, 5, 4);
      rdc("shr res", ra(6), 32'hffff_ffae);
      rdc("shr flags", ans_pkg::OFS_FLAGS, 32'h0000_0029);
      wr(ans_pkg::OFS_IMM, 32'h0000_0080);
      go(2'h2, 2'h3, 6, 0, 0);
      rdc("zero count res", ra(6), 32'hffff_ffae);
      rdc("zero count flags", ans_pkg::OFS_FLAGS, 32'h28);
      wr(ans_pkg::OFS_IMM, 32'h0000_0060);
      go(2'h2, 2'h3, 6, 0, 0);
      rdc("shift -32 res", ra(6), 32'hffff_ffff);
      wr(ans_pkg::OFS_IMM, 32'h0000_0001);
      go(2'h2, 2'h3, 6, 0, 0);
      rdc("shl one flags", ans_pkg::OFS_FLAGS, 32'h0000_0029);
      wr(ans_pkg::OFS_IMM, 32'h0000_007f);
      go(2'h2, 2'h3, 6, 0, 0);
      rdc("shr one res", ra(6), 32'hffff_ffff);
      go(2'h1, 2'h0, 9, 3, 5);
      rdc("far dst flags", ans_pkg::OFS_FLAGS, 32'h28);
      rdc("far dst result", ans_pkg::OFS_RESULT, 32'h4000_0000);
      $display("test shift done");
   endtask : t_shift
   task automatic t_irq();
      rdc("sticky events", ans_pkg::OFS_INT_STAT, 32'h3);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(ans_pkg::OFS_INT_EN, 32'h2);
      repeat (2) @(posedge clk);
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(ans_pkg::OFS_INT_CLR, 32'h2);
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rdc("events left", ans_pkg::OFS_INT_STAT, 32'h1);
      rdc("unmapped", 8'h1c, 32'h0);
      chk("resp okay", 32'h0, {31'h0, hresp});
      // Enable low: a write must not land
      ce <= 1'b0;
      wr(ans_pkg::OFS_INT_EN, 32'h1);
      ce <= 1'b1;
      rdc("frozen enable", ans_pkg::OFS_INT_EN, 32'h2);
      $display("test interrupt done");
   endtask : t_irq
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("irq after reset", 32'h0, {31'h0, irq});
      t_andc();
      t_shift();
      t_irq();
      stop_test();
   end
endmodule : ans_unit_tb
